/* File: rtl/pic_map.svh */
// Purpose: Named constants of the priority interrupt controller
// Assumes: Included by its bare name
// Notes:   Field codes, level codes and reset values
`ifndef PIC_MAP_SVH
`define PIC_MAP_SVH
// ==========================================================
// Priority field and level encodings
`define PIC_FLD_OFF     2'h0
`define PIC_FIXED_LVL   2'h3
`define PIC_FAST_LVL    2'h2
`define PIC_LVL0        2'h0
`define PIC_LVL1        2'h1
// ==========================================================
// Serviced level codes
`define PIC_CODE_NONE   2'h0
`define PIC_CODE_L0     2'h1
`define PIC_CODE_L1     2'h2
`define PIC_CODE_L23    2'h3
// ==========================================================
// Reset values
`define PIC_BOOT_ADDR   21'h000000
`define PIC_VEC_RST     7'h00
`endif

/* File: rtl/pic_pkg.sv */
// Purpose: Types of the priority interrupt controller
// Assumes: Nothing
// Notes:   Constants live in pic_map.svh
package pic_pkg;
  // ==========================================================
  // Shared types
  typedef logic [1:0] pic_lvl_t;   // Level, mask or field
  typedef logic [6:0] pic_vec_t;   // Vector number
  typedef enum logic {PIC_RUN, PIC_SLEEP} pic_pwr_t;
endpackage

/* File: rtl/pic_arbiter.sv */
// Purpose: Priority interrupt arbiter with fast-interrupt vectoring
// Assumes: Inputs synchronous to CLOCK; registers are plain ports
// Notes:   Notes on behaviour follow
// Notes on behaviour
// RULE1 - Each source above the fixed ones gets a programmable priority level
// RULE2 - Lowest source number wins within a level
// RULE3 - Normal vector is base concatenated with number
// RULE4 - Core mask gates which levels are presented
// RULE5 - Serviced level encoded as two-bit code
// RULE6 - Fast only on match and level two
// RULE7 - Fast vector taken from slot address pair
// RULE8 - Software programs level, match and address
// RULE9 - Two independent fast slots
// RULE10 - Fast decision ready before core fetches
// RULE11 - Core starts fast handling unless subroutine jump
// RULE12 - Pending request asks clocks restart in sleep
// RULE13 - Boot address driven after reset
// RULE14 - Request flag and jump address to core
// RULE15 - Highest enabled level chosen first
// RULE16 - Field 00 disables non-fixed sources, others levels 1-3
// RULE17 - External lines level sensitive while asleep
// RULE18 - Only pre-sleep enabled requests wake core
`timescale 1ns/1ps
`default_nettype none
`include "pic_map.svh"
module pic_arbiter #(
  parameter int NUM_SRC   = 82,  // Number of sources
  parameter int NUM_FIXED = 2,   // Sources of fixed level
  parameter int EXT_A_IDX = 2,   // Source of external line a
  parameter int EXT_B_IDX = 3,   // Source of external line b
  parameter int BASE_W    = 14   // Vector base width
) (
  input  wire logic                   CLOCK,
  input  wire logic                   RST_N,
  input  wire logic                   CE,
  input  wire logic [NUM_SRC-1:0]     IRQ_SRC,
  input  wire logic                   EXT_INT_LINE_A_N,
  input  wire logic                   EXT_INT_LINE_B_N,
  input  wire logic                   EXT_A_FALL_EDGE,
  input  wire logic                   EXT_B_FALL_EDGE,
  input  wire logic [2*NUM_SRC-1:0]   PRIORITY_LEVEL_REGS,
  input  wire logic [BASE_W-1:0]      VECTOR_BASE_REG,
  input  wire pic_pkg::pic_vec_t      FAST_MATCH_REG_0,
  input  wire pic_pkg::pic_vec_t      FAST_MATCH_REG_1,
  input  wire logic [15:0]            FAST_VECTOR_LOW_REG_0,
  input  wire logic [15:0]            FAST_VECTOR_LOW_REG_1,
  input  wire logic [BASE_W-10:0]     FAST_VECTOR_HIGH_REG_0,
  input  wire logic [BASE_W-10:0]     FAST_VECTOR_HIGH_REG_1,
  input  wire pic_pkg::pic_lvl_t      CORE_STATUS_MASK_BITS,
  input  wire logic                   IRQ_ACK,
  input  wire logic                   LOW_POWER,
  output logic                        INT_REQ,
  output logic [BASE_W+6:0]           VECTOR_ADDR,
  output pic_pkg::pic_vec_t           VECTOR_NUM,
  output logic                        FAST_INT,
  output pic_pkg::pic_lvl_t           SERVICED_LEVEL_CODE,
  output logic                        WAKE_REQ
);
  import pic_pkg::*;

  // ==========================================================
  // Declarations
  logic [NUM_SRC-1:0]  en;          // Source enabled now
  logic [NUM_SRC-1:0]  en_snap_r;   // Enables at sleep entry
  logic [NUM_SRC-1:0]  act;         // Active and enabled
  pic_lvl_t            lvl [NUM_SRC]; // Level per source
  logic [1:0]          ext_lat_r;   // Falling-edge latches
  logic [1:0]          ext_prev_r;  // Previous line levels
  logic [1:0]          ext_lvl;     // Active-high line levels
  logic [1:0]          ext_edge;    // Edge mode per line
  logic [1:0]          ext_req;     // Line request seen
  logic [1:0]          ext_clr;     // Latch cleared by ack
  pic_pwr_t            pwr_r;       // Power state
  logic                found;       // Some request permitted
  pic_lvl_t            best_lvl;    // Winning level
  pic_vec_t            best_idx;    // Winning number
  logic                hit0;        // Fast slot 0 matches
  logic                hit1;        // Fast slot 1 matches
  pic_lvl_t            win_lvl_r;   // Level of presented request
  logic                boot_r;      // Boot address still shown

  assign ext_lvl  = {~EXT_INT_LINE_B_N, ~EXT_INT_LINE_A_N};
  assign ext_edge = {EXT_B_FALL_EDGE, EXT_A_FALL_EDGE};

  // ==========================================================
  // Per-source level decode and request qualification
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
      logic raw;  // Request before enable
      // Fixed sources sit at top level, others from field
      assign lvl[gi] = (gi < NUM_FIXED) ? `PIC_FIXED_LVL
                     : PRIORITY_LEVEL_REGS[2*gi +: 2]; // RULE1
      // Field 00 disables the source unless it is a fixed source
      assign en[gi] = (gi < NUM_FIXED) ||
                      (PRIORITY_LEVEL_REGS[2*gi +: 2] != `PIC_FLD_OFF); // RULE16
      assign raw = (gi == EXT_A_IDX) ? ext_req[0]
                 : (gi == EXT_B_IDX) ? ext_req[1] : IRQ_SRC[gi];
      // Asleep, only enables captured at entry count
      assign act[gi] = raw && ((pwr_r == PIC_SLEEP) ? en_snap_r[gi] : en[gi]); // RULE18
    end
  endgenerate

  // ==========================================================
  // External lines: edge latch awake in edge mode, level in level mode or while asleep
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      if (pwr_r == PIC_SLEEP || !ext_edge[k]) begin
        ext_req[k] = ext_lvl[k]; // RULE17
      end else begin
        ext_req[k] = ext_lat_r[k];
      end
    end
  end

  // Ack of the line's own vector clears its latch
  assign ext_clr[0] = IRQ_ACK && INT_REQ && (VECTOR_NUM == 7'(EXT_A_IDX));
  assign ext_clr[1] = IRQ_ACK && INT_REQ && (VECTOR_NUM == 7'(EXT_B_IDX));

  // Edge latch; a new edge wins over a clear
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      ext_lat_r  <= 2'h0;
      ext_prev_r <= 2'h0;
    end else if (CE) begin
      ext_prev_r <= ext_lvl;
      ext_lat_r  <= (ext_lat_r & ~ext_clr) | (ext_lvl & ~ext_prev_r);
    end
  end

  // ==========================================================
  // Arbitration: highest level, then lowest number
  always_comb begin
    found    = 1'b0;
    best_lvl = `PIC_FLD_OFF;
    best_idx = `PIC_VEC_RST;
    // Descending scan so ties fall to the lowest number
    for (int i = NUM_SRC-1; i >= 0; i--) begin
      if (act[i] && (lvl[i] >= CORE_STATUS_MASK_BITS) && // RULE4
          (!found || lvl[i] >= best_lvl)) begin // RULE15 RULE2
        found    = 1'b1;
        best_lvl = lvl[i];
        best_idx = 7'(i);
      end
    end
  end

  // Fast slot matching, slot 0 first
  assign hit0 = (best_idx == FAST_MATCH_REG_0) && (best_lvl == `PIC_FAST_LVL); // RULE6 RULE9
  assign hit1 = (best_idx == FAST_MATCH_REG_1) && (best_lvl == `PIC_FAST_LVL); // RULE6 RULE9

  // ==========================================================
  // Request and vector presented to the core
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      INT_REQ     <= 1'b0;
      VECTOR_ADDR <= `PIC_BOOT_ADDR; // RULE13
      VECTOR_NUM  <= `PIC_VEC_RST;
      FAST_INT    <= 1'b0;
      win_lvl_r   <= `PIC_FLD_OFF;
      boot_r      <= 1'b1;
    end else if (CE) begin
      INT_REQ <= found; // RULE14
      if (found) begin
        boot_r     <= 1'b0;
        VECTOR_NUM <= best_idx;
        win_lvl_r  <= best_lvl;
        FAST_INT   <= hit0 || hit1; // RULE10
        if (hit0) begin
          VECTOR_ADDR <= {FAST_VECTOR_HIGH_REG_0, FAST_VECTOR_LOW_REG_0}; // RULE7
        end else if (hit1) begin
          VECTOR_ADDR <= {FAST_VECTOR_HIGH_REG_1, FAST_VECTOR_LOW_REG_1}; // RULE7
        end else begin
          VECTOR_ADDR <= {VECTOR_BASE_REG, best_idx}; // RULE3
        end
      end else if (boot_r) begin
        VECTOR_ADDR <= `PIC_BOOT_ADDR; // RULE13
      end
    end
  end

  // ==========================================================
  // Serviced level code, taken on core acknowledge
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      SERVICED_LEVEL_CODE <= `PIC_CODE_NONE;
    end else if (CE && IRQ_ACK && INT_REQ) begin
      case (win_lvl_r) // RULE5
        `PIC_LVL0: SERVICED_LEVEL_CODE <= `PIC_CODE_L0;
        `PIC_LVL1: SERVICED_LEVEL_CODE <= `PIC_CODE_L1;
        default: SERVICED_LEVEL_CODE <= `PIC_CODE_L23;
      endcase
    end
  end

  // ==========================================================
  // Power state, enable snapshot and wake request
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      pwr_r     <= PIC_RUN;
      en_snap_r <= '0;
      WAKE_REQ  <= 1'b0;
    end else if (CE) begin
      WAKE_REQ <= (pwr_r == PIC_SLEEP) && (|act); // RULE12
      case (pwr_r)
        PIC_RUN: begin
          // Capture enables on entry
          if (LOW_POWER) begin
            pwr_r     <= PIC_SLEEP;
            en_snap_r <= en; // RULE18
          end
        end
        PIC_SLEEP: begin
          if (!LOW_POWER) begin
            pwr_r <= PIC_RUN;
          end
        end
        default: pwr_r <= PIC_RUN;
      endcase
    end
  end

  // ==========================================================
  // Assertions
  sequence s_took;
    CE && found;
  endsequence

  sequence s_ack;
    CE && IRQ_ACK && INT_REQ;
  endsequence

  a_req_follows: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE14
    s_took |=> INT_REQ && VECTOR_NUM == $past(best_idx))
    else $error("request not presented");

  a_mask_gate: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE4
    s_took |=> win_lvl_r >= $past(CORE_STATUS_MASK_BITS))
    else $error("masked level presented");

  a_lowest_num: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE2
    s_took |-> act[best_idx] && (best_idx == 7'h00 || !act[best_idx - 7'h01]
      || lvl[best_idx - 7'h01] != best_lvl))
    else $error("lower number skipped");

  a_fast_level: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE6
    CE && FAST_INT |-> win_lvl_r == `PIC_FAST_LVL)
    else $error("fast at wrong level");

  a_fast_addr: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE7
    s_took ##0 (hit0) |=> VECTOR_ADDR == {$past(FAST_VECTOR_HIGH_REG_0), $past(FAST_VECTOR_LOW_REG_0)})
    else $error("fast address wrong");

  a_normal_addr: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE3
    s_took ##0 (!hit0 && !hit1) |=> VECTOR_ADDR == {$past(VECTOR_BASE_REG), $past(best_idx)})
    else $error("normal address wrong");

  a_level_code: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE5
    s_ack ##0 (win_lvl_r == `PIC_LVL1) |=> SERVICED_LEVEL_CODE == `PIC_CODE_L1)
    else $error("level code wrong");

  a_level_top: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE5
    s_ack ##0 (win_lvl_r >= `PIC_FAST_LVL) |=> SERVICED_LEVEL_CODE == `PIC_CODE_L23)
    else $error("top level code wrong");

  a_ce_freeze: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE14
    !CE |=> $stable(INT_REQ) && $stable(VECTOR_ADDR) && $stable(VECTOR_NUM))
    else $error("outputs moved while frozen");

  a_boot_addr: assert property (@(posedge CLOCK) // RULE13
    !RST_N |=> VECTOR_ADDR == `PIC_BOOT_ADDR && !INT_REQ)
    else $error("boot address missing");

  a_wake_req: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE12
    CE && pwr_r == PIC_SLEEP && (|act) |=> WAKE_REQ)
    else $error("wake not requested");

endmodule
`default_nettype wire

/* File: dv/pic_core_model.sv */
// Purpose: Core-side partner that takes presented vectors
// Assumes: Acks only while the bench allows it
// Notes:   Ack is a one-cycle pulse, never two in a row
`timescale 1ns/1ps
`default_nettype none
module pic_core_model (
  input  wire logic CLOCK,
  input  wire logic RST_N,
  input  wire logic TAKE_EN,
  input  wire logic INT_REQ,
  output logic      IRQ_ACK
);
  // ==========================================================
  // Ack pulse
  // Takes a vector only while a request is shown
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      IRQ_ACK <= 1'b0;
    end else begin
      IRQ_ACK <= TAKE_EN && INT_REQ && !IRQ_ACK;
    end
  end
endmodule
`default_nettype wire

/* File: dv/prioritized_interrupt_controller_tb.sv */
// Purpose: Self-checking bench of the interrupt arbiter
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Outputs checked two edges after each change
`timescale 1ns/1ps
`default_nettype none
module prioritized_interrupt_controller_tb;
  import pic_pkg::*;
  // ==========================================================
  // Stimulus and observed signals
  logic          clock = 1'b0;
  logic          rst_n, ext_a_n, ext_a_fe, low_power, take_en, ack;
  logic          ce, ext_b_n, ext_b_fe;
  logic [81:0]   irq_src;    // Raw sources
  logic [163:0]  prio;       // Priority fields
  logic [13:0]   vbase;      // Vector base
  pic_vec_t      fm0, fm1, vec_num;
  logic [15:0]   lo0, lo1;
  logic [4:0]    hi0, hi1;
  pic_lvl_t      mask, code;
  logic          int_req, fast, wake;
  logic [20:0]   vec_addr;
  int            mismatches = 0;
  int            n_checks = 0;
  // ==========================================================
  // Clock
  always #5 clock = ~clock;
  pic_arbiter uut (.CLOCK(clock), .RST_N(rst_n), .CE(ce), .IRQ_SRC(irq_src),
    .EXT_INT_LINE_A_N(ext_a_n), .EXT_INT_LINE_B_N(ext_b_n), .EXT_A_FALL_EDGE(ext_a_fe),
    .EXT_B_FALL_EDGE(ext_b_fe), .PRIORITY_LEVEL_REGS(prio), .VECTOR_BASE_REG(vbase),
    .FAST_MATCH_REG_0(fm0), .FAST_MATCH_REG_1(fm1), .FAST_VECTOR_LOW_REG_0(lo0),
    .FAST_VECTOR_LOW_REG_1(lo1), .FAST_VECTOR_HIGH_REG_0(hi0), .FAST_VECTOR_HIGH_REG_1(hi1),
    .CORE_STATUS_MASK_BITS(mask), .IRQ_ACK(ack), .LOW_POWER(low_power), .INT_REQ(int_req),
    .VECTOR_ADDR(vec_addr), .VECTOR_NUM(vec_num), .FAST_INT(fast),
    .SERVICED_LEVEL_CODE(code), .WAKE_REQ(wake));
  pic_core_model core (.CLOCK(clock), .RST_N(rst_n), .TAKE_EN(take_en),
    .INT_REQ(int_req), .IRQ_ACK(ack));
  // ==========================================================
  // Helpers
  task automatic settle;
    repeat (2) @(posedge clock);
    #1;
  endtask
  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic setp(input int i, input pic_lvl_t v);
    prio[2*i+:2] = v;
  endtask
  // Lets the core take a few vectors
  task automatic take;
    take_en = 1'b1;
    repeat (3) @(posedge clock);
    #1;
    take_en = 1'b0;
    settle;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // Watchdog
  initial begin
    #100000;
    mismatches++;
    finish_test;
  end
  // ==========================================================
  // Main sequence
  initial begin
    irq_src = '0;
    prio = '0;
    ce = 1'b1;
    ext_a_n = 1'b1;
    ext_b_n = 1'b1;
    ext_a_fe = 1'b1;
    ext_b_fe = 1'b0;
    low_power = 1'b0;
    vbase = 14'h2A5B;
    fm0 = 7'h7F;
    fm1 = 7'h7F;
    lo0 = 16'hBEEF;
    lo1 = 16'h1234;
    hi0 = 5'h15;
    hi1 = 5'h0A;
    mask = 2'h0;
    take_en = 1'b0;
    rst_n = 1'b0;
    repeat (10) @(posedge clock);
    #1;
    rst_n = 1'b1;
    settle;
    chk(int_req, 21'h0);
    chk(vec_addr, 21'h0);
    chk(code, 21'h0);
    chk(wake, 21'h0);
    // Two level-2 sources, lowest number wins
    setp(10, 2'h2);
    setp(20, 2'h2);
    setp(30, 2'h3);
    setp(50, 2'h1);
    irq_src[10] = 1'b1;
    irq_src[20] = 1'b1;
    settle;
    chk(int_req, 21'h1);
    chk(vec_num, 21'h0A);
    chk(vec_addr, {vbase, 7'h0A});
    chk(fast, 21'h0);
    irq_src[30] = 1'b1;
    settle;
    chk(vec_num, 21'h1E);
    mask = 2'h3;
    settle;
    chk(vec_num, 21'h1E);
    irq_src[30] = 1'b0;
    irq_src[10] = 1'b0;
    irq_src[20] = 1'b0;
    irq_src[60] = 1'b1;
    settle;
    chk(int_req, 21'h0);
    irq_src[50] = 1'b1;
    mask = 2'h2;
    settle;
    chk(int_req, 21'h0);
    mask = 2'h1;
    settle;
    chk(vec_num, 21'h32);
    take;
    chk(code, 21'h2);
    // Fast slot 0, then slot 1, then a level-3 match
    fm0 = 7'h0A;
    irq_src[50] = 1'b0;
    irq_src[10] = 1'b1;
    settle;
    chk(fast, 21'h1);
    chk(vec_addr, {hi0, lo0});
    take;
    chk(code, 21'h3);
    fm1 = 7'h14;
    irq_src[10] = 1'b0;
    irq_src[20] = 1'b1;
    settle;
    chk(fast, 21'h1);
    chk(vec_addr, {hi1, lo1});
    fm1 = 7'h1E;
    irq_src[20] = 1'b0;
    irq_src[30] = 1'b1;
    settle;
    chk(fast, 21'h0);
    chk(vec_addr, {vbase, 7'h1E});
    // Clock enable low freezes the presented request
    ce = 1'b0;
    irq_src[30] = 1'b0;
    settle;
    chk(int_req, 21'h1);
    ce = 1'b1;
    settle;
    chk(int_req, 21'h0);
    irq_src[60] = 1'b0;
    // Sleep: only sources enabled before entry wake
    setp(40, 2'h1);
    setp(2, 2'h1);
    low_power = 1'b1;
    settle;
    setp(41, 2'h1);
    irq_src[41] = 1'b1;
    settle;
    chk(wake, 21'h0);
    irq_src[40] = 1'b1;
    settle;
    chk(wake, 21'h1);
    irq_src[40] = 1'b0;
    irq_src[41] = 1'b0;
    settle;
    chk(wake, 21'h0);
    ext_a_n = 1'b0;
    settle;
    chk(wake, 21'h1);
    // Awake again, line a is edge mode: latch holds until ack
    low_power = 1'b0;
    ext_a_n = 1'b1;
    settle;
    chk(wake, 21'h0);
    chk(int_req, 21'h1);
    chk(vec_num, 21'h02);
    take;
    chk(int_req, 21'h0);
    chk(code, 21'h2);
    // One-cycle low pulse is caught by the edge latch
    ext_a_n = 1'b0;
    @(posedge clock);
    #1;
    ext_a_n = 1'b1;
    settle;
    chk(int_req, 21'h1);
    chk(vec_num, 21'h02);
    take;
    chk(int_req, 21'h0);
    // Line b in level mode follows the pin
    setp(3, 2'h2);
    ext_b_n = 1'b0;
    settle;
    chk(vec_num, 21'h03);
    chk(vec_addr, {vbase, 7'h03});
    ext_b_n = 1'b1;
    settle;
    chk(int_req, 21'h0);
    finish_test;
  end
endmodule
`default_nettype wire
